// >>> include/rtc_pkg.sv
// Constants, register map and state types of the calendar clock
`default_nettype none

package rtc_pkg;

  // Timebase
  localparam int unsigned OSC_HZ = 32768;
  localparam logic [14:0] DIV_TOP = 15'(OSC_HZ - 1);

  // Periodic interrupt period limits, in their own units
  localparam int unsigned PER_MIN_US = 122;
  localparam int unsigned PER_MAX_MS = 500;
  localparam int unsigned PER_MIN_TICKS = (PER_MIN_US * OSC_HZ + 500000) / 1000000;
  localparam int unsigned PER_MAX_TICKS = (PER_MAX_MS * OSC_HZ + 500) / 1000;
  localparam logic [3:0] RATE_MIN = 4'($clog2(PER_MIN_TICKS) + 1);
  localparam logic [3:0] RATE_MAX = 4'($clog2(PER_MAX_TICKS) + 1);

  // Field limits
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [4:0] HOUR_NOON = 5'h0C;
  localparam logic [2:0] DOW_MAX = 3'h7;
  localparam logic [3:0] MON_MAX = 4'hC;
  localparam logic [6:0] YEAR_MAX = 7'h63;

  // Register byte offsets
  localparam logic [7:0] ADR_SEC = 8'h00;
  localparam logic [7:0] ADR_MIN = 8'h04;
  localparam logic [7:0] ADR_HOUR = 8'h08;
  localparam logic [7:0] ADR_DOW = 8'h0C;
  localparam logic [7:0] ADR_DOM = 8'h10;
  localparam logic [7:0] ADR_MON = 8'h14;
  localparam logic [7:0] ADR_YEAR = 8'h18;
  localparam logic [7:0] ADR_ALM_SEC = 8'h1C;
  localparam logic [7:0] ADR_ALM_MIN = 8'h20;
  localparam logic [7:0] ADR_ALM_HOUR = 8'h24;
  localparam logic [7:0] ADR_ALM_DOM = 8'h28;
  localparam logic [7:0] ADR_CTRL = 8'h2C;
  localparam logic [7:0] ADR_STATUS = 8'h30;
  localparam logic [7:0] ADR_MASK = 8'h34;
  localparam logic [7:0] ADR_DIV = 8'h38;

  // Status and mask bit positions
  localparam int unsigned EV_ALM = 0;
  localparam int unsigned EV_PER = 1;
  localparam int unsigned EV_UPD = 2;

  // Alarm match enable positions
  localparam int unsigned AEN_SEC = 0;
  localparam int unsigned AEN_MIN = 1;
  localparam int unsigned AEN_HOUR = 2;
  localparam int unsigned AEN_DOM = 3;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADV = 2'b01,
    PH_DONE = 2'b10
  } phase_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] mon;
    logic [4:0] dom;
    logic [2:0] dow;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } time_t;

  typedef struct packed {
    logic [3:0] aen;
    logic [3:0] rate;
    logic halt;
    logic bin;
    logic h24;
  } ctrl_t;

  typedef struct packed {
    time_t tm;
    time_t alm;
    ctrl_t ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [14:0] div;
    logic osc;
    phase_t phase;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } state_t;

  localparam time_t TIME_RST = '{year: 7'h00, mon: 4'h1, dom: 5'h01, dow: 3'h1,
                                 hour: 5'h00, min: 6'h00, sec: 6'h00};
  localparam ctrl_t CTRL_RST = '{aen: 4'h0, rate: 4'h0, halt: 1'b0, bin: 1'b0, h24: 1'b1};

endpackage

`default_nettype wire

// >>> verilog/rtc_calendar.sv
// Calendar clock with alarm, periodic and update-end interrupts, Wishbone slave
//
// Behaviour
// RULE_01 - Divide the 32.768 kHz oscillator so counters advance once per second.
// RULE_02 - Keep seconds, minutes, hours, day, weekday, month and year counters.
// RULE_03 - Hours read and write in 12-hour or 24-hour form per control bit.
// RULE_04 - All time values read and write as packed BCD or binary per control bit.
// RULE_05 - Three interrupt sources: alarm, periodic, and update ended.
// RULE_06 - Alarm compares selected fields, from every second up to once a month.
// RULE_07 - Periodic interrupt at selectable rates from 122 us to 500 ms.
// RULE_08 - Flag update ended after each once-per-second counter update.
// RULE_09 - Month lengths, leap years, weekday wrap at seven, consistent hour wrap.
`default_nettype none

module rtc_calendar
  import rtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Format helpers

  // Binary value to external form
  function automatic logic [7:0] enc(input logic [6:0] v, input logic bin);
    logic [6:0] tens;
    logic [6:0] ones;
    tens = v / 7'd10;
    ones = v % 7'd10;
    enc = bin ? {1'b0, v} : {tens[3:0], ones[3:0]};
  endfunction

  // External form to binary value
  function automatic logic [6:0] dec(input logic [7:0] v, input logic bin);
    dec = bin ? v[6:0] : 7'(7'(v[7:4]) * 7'd10 + 7'(v[3:0]));
  endfunction

  // Hour out, bit 7 is PM in 12-hour form
  function automatic logic [7:0] hour_out(input logic [4:0] h, input logic h24, input logic bin);
    logic [4:0] h12;
    logic [7:0] e;
    h12 = (h == 5'h00) ? HOUR_NOON : ((h > HOUR_NOON) ? 5'(h - HOUR_NOON) : h);
    e = enc({2'b00, h12}, bin);
    hour_out = h24 ? enc({2'b00, h}, bin) : {(h >= HOUR_NOON), e[6:0]};
  endfunction

  // Hour in, 12 o'clock maps to 0 before the PM offset
  function automatic logic [4:0] hour_in(input logic [7:0] v, input logic h24, input logic bin);
    logic [6:0] h12;
    logic [4:0] base;
    h12 = dec({1'b0, v[6:0]}, bin);
    base = (h12[4:0] == HOUR_NOON) ? 5'h00 : h12[4:0];
    hour_in = h24 ? 5'(dec(v, bin)) : 5'(base + (v[7] ? HOUR_NOON : 5'h00));
  endfunction

  // Days in month; years 00..99 leap every fourth
  function automatic logic [4:0] dim(input logic [3:0] mon, input logic [6:0] year);
    case (mon)
      4'h2: dim = (year[1:0] == 2'b00) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: dim = 5'h1E;
      default: dim = 5'h1F;
    endcase
  endfunction

  // Divider mask for a rate select; low codes clamp to the fastest rate
  function automatic logic [14:0] per_mask(input logic [3:0] rate);
    logic [3:0] r;
    r = (rate < RATE_MIN) ? RATE_MIN : rate;
    per_mask = 15'((16'h0001 << (r - 4'h1)) - 16'h0001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t q;
  state_t d;
  logic osc_rise;
  logic sec_tick;
  logic per_hit;
  logic alm_match;
  logic req;
  logic wr;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic [7:0] wbyte;
  logic [31:0] rd;
  logic tm_open;

  assign req = wb_cyc_i & wb_stb_i;
  // Time fields take writes only while halted and idle, so no race with updates
  assign tm_open = q.ctrl.halt && q.phase == PH_IDLE;
  // Write lands on the edge where the master sees ack
  assign wr = req & q.ack & wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  // Alarm: disabled fields match anything, so no enables means every second
  assign alm_match = (!q.ctrl.aen[AEN_SEC] || q.tm.sec == q.alm.sec) &&
                     (!q.ctrl.aen[AEN_MIN] || q.tm.min == q.alm.min) &&
                     (!q.ctrl.aen[AEN_HOUR] || q.tm.hour == q.alm.hour) &&
                     (!q.ctrl.aen[AEN_DOM] || q.tm.dom == q.alm.dom); // [RULE_06]

  // Read data in the selected format
  always_comb
  begin
    rd = 32'h0000_0000;
    case ({wb_adr_i[7:2], 2'b00})
      ADR_SEC: rd[7:0] = enc({1'b0, q.tm.sec}, q.ctrl.bin); // [RULE_04]
      ADR_MIN: rd[7:0] = enc({1'b0, q.tm.min}, q.ctrl.bin);
      ADR_HOUR: rd[7:0] = hour_out(q.tm.hour, q.ctrl.h24, q.ctrl.bin); // [RULE_03]
      ADR_DOW: rd[7:0] = enc({4'h0, q.tm.dow}, q.ctrl.bin);
      ADR_DOM: rd[7:0] = enc({2'b00, q.tm.dom}, q.ctrl.bin);
      ADR_MON: rd[7:0] = enc({3'b000, q.tm.mon}, q.ctrl.bin);
      ADR_YEAR: rd[7:0] = enc(q.tm.year, q.ctrl.bin);
      ADR_ALM_SEC: rd[7:0] = enc({1'b0, q.alm.sec}, q.ctrl.bin);
      ADR_ALM_MIN: rd[7:0] = enc({1'b0, q.alm.min}, q.ctrl.bin);
      ADR_ALM_HOUR: rd[7:0] = hour_out(q.alm.hour, q.ctrl.h24, q.ctrl.bin);
      ADR_ALM_DOM: rd[7:0] = enc({2'b00, q.alm.dom}, q.ctrl.bin);
      ADR_CTRL: rd[11:0] = {q.ctrl.aen, q.ctrl.rate, 1'b0, q.ctrl.halt, q.ctrl.bin, q.ctrl.h24};
      ADR_STATUS: rd[2:0] = q.status;
      ADR_MASK: rd[2:0] = q.mask;
      ADR_DIV: rd[14:0] = q.div;
      default: rd = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    ev_set = 3'b000;
    ev_clr = 3'b000;
    sec_tick = 1'b0;
    per_hit = 1'b0;

    // Oscillator is sampled as a synchronous level; count its rising edges
    d.osc = osc_i;
    osc_rise = osc_i & ~q.osc;
    if (osc_rise)
    begin
      d.div = (q.div == DIV_TOP) ? 15'h0000 : 15'(q.div + 15'h0001); // [RULE_01]
      sec_tick = (q.div == DIV_TOP) && !q.ctrl.halt; // [RULE_01]
      per_hit = (q.ctrl.rate != 4'h0) &&
                ((q.div & per_mask(q.ctrl.rate)) == per_mask(q.ctrl.rate)); // [RULE_07]
    end
    if (per_hit)
    begin
      ev_set[EV_PER] = 1'b1; // [RULE_05]
    end

    // Update sequence: advance one cycle, then flag and check alarm
    case (q.phase)
      PH_IDLE:
      begin
        if (sec_tick)
        begin
          d.phase = PH_ADV;
        end
      end
      PH_ADV:
      begin
        d.phase = PH_DONE;
        if (q.tm.sec != SEC_MAX)
        begin
          d.tm.sec = 6'(q.tm.sec + 6'h01); // [RULE_02]
        end
        else
        begin
          d.tm.sec = 6'h00;
          if (q.tm.min != MIN_MAX)
          begin
            d.tm.min = 6'(q.tm.min + 6'h01);
          end
          else
          begin
            d.tm.min = 6'h00;
            // Hours count 0..23 inside, so 12-hour view wraps with it
            if (q.tm.hour != HOUR_MAX)
            begin
              d.tm.hour = 5'(q.tm.hour + 5'h01); // [RULE_09]
            end
            else
            begin
              d.tm.hour = 5'h00;
              d.tm.dow = (q.tm.dow == DOW_MAX) ? 3'h1 : 3'(q.tm.dow + 3'h1); // [RULE_09]
              if (q.tm.dom < dim(q.tm.mon, q.tm.year))
              begin
                d.tm.dom = 5'(q.tm.dom + 5'h01);
              end
              else
              begin
                d.tm.dom = 5'h01; // [RULE_09]
                if (q.tm.mon != MON_MAX)
                begin
                  d.tm.mon = 4'(q.tm.mon + 4'h1);
                end
                else
                begin
                  d.tm.mon = 4'h1;
                  d.tm.year = (q.tm.year == YEAR_MAX) ? 7'h00 : 7'(q.tm.year + 7'h01);
                end
              end
            end
          end
        end
      end
      PH_DONE:
      begin
        d.phase = PH_IDLE;
        ev_set[EV_UPD] = 1'b1; // [RULE_08]
        if (alm_match)
        begin
          ev_set[EV_ALM] = 1'b1; // [RULE_06]
        end
      end
      default:
      begin
        d.phase = PH_IDLE;
      end
    endcase

    // Bus: ack one cycle after the request, read data captured with it
    d.ack = req & ~q.ack;
    if (req & ~q.ack)
    begin
      d.dat = rd;
    end

    // Register writes; time fields only while halted and idle, so no race with updates
    if (wr && wb_sel_i[0])
    begin
      case ({wb_adr_i[7:2], 2'b00})
        ADR_SEC: if (tm_open) d.tm.sec = 6'(dec(wbyte, q.ctrl.bin)); // [RULE_04]
        ADR_MIN: if (tm_open) d.tm.min = 6'(dec(wbyte, q.ctrl.bin));
        ADR_HOUR: if (tm_open) d.tm.hour = hour_in(wbyte, q.ctrl.h24, q.ctrl.bin); // [RULE_03]
        ADR_DOW: if (tm_open) d.tm.dow = 3'(dec(wbyte, q.ctrl.bin));
        ADR_DOM: if (tm_open) d.tm.dom = 5'(dec(wbyte, q.ctrl.bin));
        ADR_MON: if (tm_open) d.tm.mon = 4'(dec(wbyte, q.ctrl.bin));
        ADR_YEAR: if (tm_open) d.tm.year = dec(wbyte, q.ctrl.bin);
        ADR_ALM_SEC: d.alm.sec = 6'(dec(wbyte, q.ctrl.bin));
        ADR_ALM_MIN: d.alm.min = 6'(dec(wbyte, q.ctrl.bin));
        ADR_ALM_HOUR: d.alm.hour = hour_in(wbyte, q.ctrl.h24, q.ctrl.bin);
        ADR_ALM_DOM: d.alm.dom = 5'(dec(wbyte, q.ctrl.bin));
        ADR_CTRL:
        begin
          d.ctrl.h24 = wbyte[0]; // [RULE_03]
          d.ctrl.bin = wbyte[1]; // [RULE_04]
          d.ctrl.halt = wbyte[2];
          d.ctrl.rate = wbyte[7:4]; // [RULE_07]
        end
        ADR_STATUS: ev_clr = wbyte[2:0];
        ADR_MASK: d.mask = wbyte[2:0];
        default: ev_clr = 3'b000;
      endcase
    end
    if (wr && wb_sel_i[1] && {wb_adr_i[7:2], 2'b00} == ADR_CTRL)
    begin
      d.ctrl.aen = wb_dat_i[11:8]; // [RULE_06]
    end

    // Sticky flags, an event in the clearing cycle survives
    d.status = (q.status & ~ev_clr) | ev_set; // [RULE_05]
    d.irq = |(d.status & d.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '{tm: TIME_RST, alm: TIME_RST, ctrl: CTRL_RST, status: 3'h0, mask: 3'h0,
             div: 15'h0000, osc: 1'b0, phase: PH_IDLE, ack: 1'b0, dat: 32'h0000_0000, irq: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_tick_starts_update: assert property ( // [RULE_01]
    (osc_rise && q.div == DIV_TOP && !q.ctrl.halt && q.phase == PH_IDLE) |=> q.phase == PH_ADV ##1 q.phase == PH_DONE)
    else $error("second tick did not start the update");

  a_sec_advance: assert property ( // [RULE_02]
    (q.phase == PH_ADV)
    |=> q.tm.sec == (($past(q.tm.sec) == SEC_MAX) ? 6'h00 : 6'($past(q.tm.sec) + 6'h01)))
    else $error("seconds did not advance by one");

  a_hour_view: assert property ( // [RULE_03]
    (req && !q.ack && !q.ctrl.h24 && !q.ctrl.bin && {wb_adr_i[7:2], 2'b00} == ADR_HOUR && q.tm.hour == 5'h00)
    |=> wb_dat_o[7:0] == 8'h12)
    else $error("midnight not read as 12 AM");

  a_bcd_read: assert property ( // [RULE_04]
    (req && !q.ack && !q.ctrl.bin && {wb_adr_i[7:2], 2'b00} == ADR_SEC && q.tm.sec == 6'h2D) |=> wb_dat_o[7:0] == 8'h45)
    else $error("seconds not read as BCD");

  a_irq_follow: assert property ( // [RULE_05]
    irq_o == |(q.status & q.mask))
    else $error("interrupt out of step with flags");

  a_alarm_fire: assert property ( // [RULE_06]
    (q.phase == PH_DONE && alm_match) |=> q.status[EV_ALM])
    else $error("alarm match did not set its flag");

  a_periodic_fire: assert property ( // [RULE_07]
    per_hit |=> q.status[EV_PER])
    else $error("periodic hit did not set its flag");

  a_update_end: assert property ( // [RULE_08]
    (q.phase == PH_ADV) |=> ##1 q.status[EV_UPD])
    else $error("update end not flagged two cycles after advance");

  a_dow_wrap: assert property ( // [RULE_09]
    (q.phase == PH_ADV && q.tm.sec == SEC_MAX && q.tm.min == MIN_MAX && q.tm.hour == HOUR_MAX && q.tm.dow == DOW_MAX)
    |=> q.tm.dow == 3'h1 && q.tm.hour == 5'h00)
    else $error("weekday or hour did not wrap");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// >>> tb/rtc_calendar_bench.sv
// Self-checking bench for the calendar clock: bus access, formats, interrupts, one second tick
`default_nettype none

module rtc_calendar_bench
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic osc_prev = 1'b0;
  int osc_cnt = 0;
  int err_count = 0;
  int total_checks = 0;

  rtc_calendar dut (.clk_i(clk_i), .rst_i(rst_i), .osc_i(osc_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and fastest legal oscillator: one clock high, one low
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    forever
    begin
      @(posedge clk_i);
      osc_i <= ~osc_i;
    end
  end

  // Count oscillator rises the way the block samples them
  always @(posedge clk_i)
  begin
    osc_prev <= osc_i;
    if (rst_i)
      osc_cnt <= 0;
    else if (osc_i && !osc_prev)
      osc_cnt <= osc_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Slave answers one cycle after it first sees the request
    check("wb_ack_delay", 32'(n), 32'h2);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rc(ADR_SEC, 32'h0, "sec_reset");
    rc(ADR_DOW, 32'h1, "dow_reset");
    rc(ADR_CTRL, 32'h001, "ctrl_reset");
    rc(ADR_STATUS, 32'h0, "status_reset");
    wr(8'h3C, 32'hFF);
    rc(8'h3C, 32'h0, "unmapped");
  endtask

  // Fastest periodic rate, first masked then unmasked
  task automatic test_periodic();
    wr(ADR_CTRL, 32'h031);
    repeat (20) @(posedge clk_i);
    check("irq_masked", {31'h0, irq}, 32'h0);
    rc(ADR_STATUS, 32'h2, "per_flag");
    wr(ADR_MASK, 32'h2);
    wait_irq(10);
    check("irq_per", {31'h0, irq}, 32'h1);
    wr(ADR_CTRL, 32'h001);
    wr(ADR_STATUS, 32'h7);
    rc(ADR_STATUS, 32'h0, "per_off_clear");
    check("irq_cleared", {31'h0, irq}, 32'h0);
  endtask

  // Time writes need halt; BCD versus binary reads, and a 24-hour hour write read back in 12-hour form
  task automatic test_format();
    wr(ADR_SEC, 32'h30);
    rc(ADR_SEC, 32'h0, "sec_no_halt");
    wr(ADR_CTRL, 32'h005);
    wr(ADR_SEC, 32'h45);
    rc(ADR_SEC, 32'h45, "sec_bcd");
    wr(ADR_CTRL, 32'h007);
    rc(ADR_SEC, 32'h2D, "sec_bcd_to_bin");
    wr(ADR_HOUR, 32'h17);
    wr(ADR_CTRL, 32'h006);
    rc(ADR_HOUR, 32'h8B, "hour_12_bin");
    wr(ADR_CTRL, 32'h004);
    rc(ADR_HOUR, 32'h91, "hour_12_bcd");
  endtask

  // Last second of 28 Feb in a non-leap year, weekday 7, alarm on every field
  task automatic test_rollover();
    logic [7:0] ta [7];
    logic [31:0] tv [7];
    logic [31:0] te [7];
    int edges;
    ta = '{ADR_SEC, ADR_MIN, ADR_HOUR, ADR_DOW, ADR_DOM, ADR_MON, ADR_YEAR};
    tv = '{32'h3B, 32'h3B, 32'h17, 32'h7, 32'h1C, 32'h2, 32'h3};
    te = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h3, 32'h3};
    wr(ADR_CTRL, 32'h007);
    for (int i = 0; i < 7; i++)
      wr(ta[i], tv[i]);
    wr(ADR_ALM_SEC, 32'h0);
    wr(ADR_MASK, 32'h5);
    wr(ADR_STATUS, 32'h7);
    // Alarm minute, hour and day keep their reset values, which match the rolled time
    wr(ADR_CTRL, 32'hF03);
    wait_irq(70000);
    edges = osc_cnt;
    check("tick_osc_edges", 32'(edges >= 32768 && edges <= 32772), 32'h1);
    rc(ADR_STATUS, 32'h5, "alarm_and_update");
    for (int i = 0; i < 7; i++)
      rc(ta[i], te[i], "rolled_field");
    wr(ADR_CTRL, 32'h100);
    rc(ADR_HOUR, 32'h12, "midnight_12_bcd");
    // Clearing one flag must leave the other standing
    wr(ADR_STATUS, 32'h1);
    rc(ADR_STATUS, 32'h4, "w1c_alarm");
    check("irq_upd_held", {31'h0, irq}, 32'h1);
    wr(ADR_STATUS, 32'h4);
    rc(ADR_STATUS, 32'h0, "w1c_update");
    check("irq_dropped", {31'h0, irq}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized above one simulated second plus setup
  initial
  begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_periodic();
    test_format();
    test_rollover();
    print_verdict();
  end

endmodule

`default_nettype wire
